// ### cpri_ctrl_word_reset_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ==========
// Bench.
module cpri_ctrl_word_reset_regs_tb;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] ex; logic er;} crc_row_t;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, codeViolation, linkResetDetected, linkResetSent, txResetRequest, resetOut;
  crc_pkg::crc_slot_t rxSlot, txSlotInsert;
  logic [11:0] frameNumber = 0;
  logic [7:0] txSlotIndex;
  logic [15:0] sendWord = 0;
  logic external_reset_request_in = 0, sendGo = 0, violGo = 0, farReset = 0;
  int num_errors = 0, n_checks = 0;
  crc_row_t rows[8] = '{'{crc_pkg::ADDR_SLOT, 32'hFFFFFF5A, 32'h5A, 0},
    '{crc_pkg::ADDR_TXCTRL, 32'hFFFFFFFF, 32'h1FF, 0}, '{crc_pkg::ADDR_CFG, 32'h1, 32'h1, 0},
    '{crc_pkg::ADDR_RXCTRL, 32'hFF, 32'h0, 0}, '{crc_pkg::ADDR_LCV, 32'hFF, 32'h0, 0},
    '{crc_pkg::ADDR_FRAME, 32'hFFF, 32'h0, 0}, '{crc_pkg::ADDR_RST, 32'h4, 32'h4, 0},
    '{8'h40, 32'hFF, 32'h0, 1}};
  // Packed as {pin level, expected request, control nibble}.
  logic [5:0] modes[4] = '{6'h13, 6'h01, 6'h38, 6'h0B};

  crc_ctrl_regs u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxSlot(rxSlot), .codeViolation(codeViolation),
    .frameNumber(frameNumber), .linkResetDetected(linkResetDetected),
    .txSlotIndex(txSlotIndex), .txSlotInsert(txSlotInsert), .linkResetSent(linkResetSent),
    .txResetRequest(txResetRequest), .external_reset_request_in(external_reset_request_in),
    .resetOut(resetOut));
  crc_link_model u_model (.clk_sys(clk_sys), .rst(rst), .sendGo(sendGo), .sendWord(sendWord),
    .violGo(violGo), .farReset(farReset), .txResetRequest(txResetRequest), .rxSlot(rxSlot),
    .codeViolation(codeViolation), .linkResetDetected(linkResetDetected),
    .txSlotIndex(txSlotIndex), .linkResetSent(linkResetSent));

  always #2 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Entered and left just after a rising edge; data are taken at the edge that shows pready.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    check(rd, exp);
  endtask

  task automatic waitIdx(input logic [7:0] t);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (txSlotIndex !== t && k < 300);
  endtask

  initial begin
    tick(20);
    rst <= 0;
    tick(1);
    foreach (rows[i]) rdchk(rows[i].a, 32'h0);
    foreach (rows[i]) begin
      xfer(1, rows[i].a, rows[i].wd);
      check({31'h0, err}, {31'h0, rows[i].er});
      rdchk(rows[i].a, rows[i].ex);
      check({31'h0, err}, {31'h0, rows[i].er});
    end
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(1);
    rdchk(crc_pkg::ADDR_TXCTRL, 32'h0);
    xfer(1, crc_pkg::ADDR_SLOT, 32'h5);
    sendGo <= 1;
    sendWord <= 16'h0633;
    tick(1);
    sendWord <= 16'h05A5;
    tick(1);
    sendWord <= 16'h0677;
    tick(1);
    sendGo <= 0;
    tick(1);
    rdchk(crc_pkg::ADDR_RXCTRL, 32'hA5);
    // Per-byte enable alone, global enable alone, then both together.
    for (int m = 1; m < 4; m++) begin
      xfer(1, crc_pkg::ADDR_TXCTRL, {23'h0, m[0], 8'h3C});
      xfer(1, crc_pkg::ADDR_CFG, {31'h0, m[1]});
      waitIdx(8'h05);
      check(txSlotInsert, {1'b1, 8'h05, 8'h3C});
      tick(1);
      check(txSlotInsert.valid, 1'b0);
      xfer(1, crc_pkg::ADDR_TXCTRL, 32'h3C);
      xfer(1, crc_pkg::ADDR_CFG, 32'h0);
      waitIdx(8'h05);
      check(txSlotInsert.valid, 1'b0);
    end
    violGo <= 1;
    tick(3);
    violGo <= 0;
    tick(2);
    rdchk(crc_pkg::ADDR_LCV, 32'h3);
    violGo <= 1;
    tick(260);
    violGo <= 0;
    tick(2);
    rdchk(crc_pkg::ADDR_LCV, 32'hFF);
    frameNumber <= 12'hABC;
    tick(2);
    rdchk(crc_pkg::ADDR_FRAME, 32'hABC);
    farReset <= 1;
    tick(3);
    check(resetOut, 1'b0);
    rdchk(crc_pkg::ADDR_RST, 32'h30);
    xfer(1, crc_pkg::ADDR_RST, 32'h4);
    tick(2);
    check(resetOut, 1'b1);
    farReset <= 0;
    tick(3);
    check(resetOut, 1'b0);
    rdchk(crc_pkg::ADDR_RST, 32'h24);
    rdchk(crc_pkg::ADDR_RST, 32'h4);
    foreach (modes[i]) begin
      xfer(1, crc_pkg::ADDR_RST, {28'h0, modes[i][3:0]});
      // In pin mode the pin level sets the reset request sent to the link.
      external_reset_request_in <= modes[i][5];
      tick(3);
      check(txResetRequest, modes[i][4]);
    end
    external_reset_request_in <= 0;
    xfer(1, crc_pkg::ADDR_RST, 32'h3);
    tick(4);
    rdchk(crc_pkg::ADDR_RST, 32'hC3);
    xfer(1, crc_pkg::ADDR_RST, 32'h0);
    tick(4);
    rdchk(crc_pkg::ADDR_RST, 32'h80);
    rdchk(crc_pkg::ADDR_RST, 32'h0);
    wrap_up();
  end

  // The whole sequence needs about 2,000 cycles.
  initial begin
    tick(20000);
    num_errors++;
    wrap_up();
  end
endmodule // cpri_ctrl_word_reset_regs_tb

`default_nettype wire

// ### crc_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none


module crc_ctrl_regs #(
  parameter int FRAME_W = 12
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive side of the link.
  input wire crc_pkg::crc_slot_t rxSlot,
  input wire logic codeViolation,
  input wire logic [FRAME_W-1:0] frameNumber,
  input wire logic linkResetDetected,
  // Transmit side of the link.
  input wire logic [7:0] txSlotIndex,
  output crc_pkg::crc_slot_t txSlotInsert,
  input wire logic linkResetSent,
  output logic txResetRequest,
  // User side.
  input wire logic external_reset_request_in,
  output logic resetOut
);

  typedef struct packed {
    logic globalInsert;
    logic [7:0] slotSel;
    logic [7:0] rxByte;
    logic txInsert;
    logic [7:0] txByte;
    logic pin_driven_reset_gen_enable;
    logic resetOutEn;
    logic resetForce;
    logic resetGenEn;
    logic detect;
    logic detectHold;
    logic done;
    logic doneHold;
    logic [31:0] rdata;
    logic slvErr;
    logic [FRAME_W-1:0] frame;
    logic txReq;
    logic resetOut;
  } crc_state_t;

  crc_state_t state_r;
  crc_state_t state_nxt;
  logic [7:0] lcvCount;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic setupEn;

  // ==========================================================
  // Line code violation counter
  // ==========================================================
  // Only for debug visibility; the count is read back over APB and used nowhere else.
  crc_lcv_counter #(.WIDTH(8)) lcvCounter (
    .clk_sys(clk_sys),
    .rst(rst),
    .violation(codeViolation),
    .count(lcvCount)
  );

  // ==========================================================
  // APB decode
  // ==========================================================
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign setupEn = psel && !penable;
  assign pready = 1'b1;

  always_comb begin
    if (paddr == crc_pkg::ADDR_CFG) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_SLOT) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_RXCTRL) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_TXCTRL) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_LCV) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_FRAME) begin
      mapped = 1'b1;
    end else if (paddr == crc_pkg::ADDR_RST) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = 32'h00000000;
    state_nxt.slvErr = 1'b0;
    state_nxt.frame = frameNumber;
    // Capture the selected entry as it arrives from the link.
    if (rxSlot.valid && (rxSlot.index == state_r.slotSel)) begin
      state_nxt.rxByte = rxSlot.data;
    end
    state_nxt.detect = linkResetDetected;
    state_nxt.done = linkResetSent;
    if (wrEn) begin
      if (paddr == crc_pkg::ADDR_CFG) begin
        state_nxt.globalInsert = pwdata[crc_pkg::CFG_INSERT_BIT];
      end else if (paddr == crc_pkg::ADDR_SLOT) begin
        state_nxt.slotSel = pwdata[7:0];
      end else if (paddr == crc_pkg::ADDR_TXCTRL) begin
        state_nxt.txInsert = pwdata[crc_pkg::TX_INSERT_BIT];
        state_nxt.txByte = pwdata[7:0];
      end else if (paddr == crc_pkg::ADDR_RST) begin
        state_nxt.resetGenEn = pwdata[crc_pkg::RST_GEN_EN_BIT];
        state_nxt.resetForce = pwdata[crc_pkg::RST_FORCE_BIT];
        state_nxt.resetOutEn = pwdata[crc_pkg::RST_OUT_EN_BIT];
        state_nxt.pin_driven_reset_gen_enable = pwdata[crc_pkg::RST_PIN_EN_BIT];
      end
    end
    // Read data and the error flag load in the setup cycle, so both stand from flip-flops
    // through the access cycle and are valid at the edge that ends the transfer.
    if (setupEn) begin
      state_nxt.slvErr = !mapped;
    end
    if (setupEn && !pwrite) begin
      if (paddr == crc_pkg::ADDR_CFG) begin
        state_nxt.rdata = {31'h00000000, state_r.globalInsert};
      end else if (paddr == crc_pkg::ADDR_SLOT) begin
        state_nxt.rdata = {24'h000000, state_r.slotSel};
      end else if (paddr == crc_pkg::ADDR_RXCTRL) begin
        state_nxt.rdata = {24'h000000, state_r.rxByte};
      end else if (paddr == crc_pkg::ADDR_TXCTRL) begin
        state_nxt.rdata = {23'h000000, state_r.txInsert, state_r.txByte};
      end else if (paddr == crc_pkg::ADDR_LCV) begin
        state_nxt.rdata = {24'h000000, lcvCount};
      end else if (paddr == crc_pkg::ADDR_FRAME) begin
        state_nxt.rdata = {{(32 - FRAME_W){1'b0}}, state_r.frame};
      end else if (paddr == crc_pkg::ADDR_RST) begin
        state_nxt.rdata = {24'h000000, state_r.doneHold, state_r.done, state_r.detectHold,
          state_r.detect, state_r.pin_driven_reset_gen_enable, state_r.resetOutEn,
          state_r.resetForce, state_r.resetGenEn};
      end
    end
    // A read clears only the hold bits it returned, so an event that lands between setup
    // and access is not lost; an event in the clearing cycle is set again below.
    if (rdEn && (paddr == crc_pkg::ADDR_RST)) begin
      state_nxt.detectHold = state_r.detectHold && !state_r.rdata[crc_pkg::RST_DET_HOLD_BIT];
      state_nxt.doneHold = state_r.doneHold && !state_r.rdata[crc_pkg::RST_DONE_HOLD_BIT];
    end
    if (linkResetDetected) begin
      state_nxt.detectHold = 1'b1;
    end
    if (linkResetSent) begin
      state_nxt.doneHold = 1'b1;
    end
    // Pin mode has priority and masks both software bits.
    if (state_r.pin_driven_reset_gen_enable) begin
      state_nxt.txReq = external_reset_request_in;
    end else if (state_r.resetGenEn) begin
      state_nxt.txReq = state_r.resetForce;
    end else begin
      state_nxt.txReq = 1'b0;
    end
    state_nxt.resetOut = state_r.resetOutEn && linkResetDetected;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata = state_r.rdata;
  assign pslverr = state_r.slvErr;
  assign txResetRequest = state_r.txReq;
  assign resetOut = state_r.resetOut;

  always_comb begin
    txSlotInsert.index = state_r.slotSel;
    txSlotInsert.data = state_r.txByte;
    // The global enable overrides the per-byte bit, so either one inserts.
    txSlotInsert.valid = state_r.globalInsert || state_r.txInsert;
    if (txSlotIndex != state_r.slotSel) begin
      txSlotInsert.valid = 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  insert_default_a: assert property (@(posedge clk_sys)
    rst |=> !txSlotInsert.valid)
    else $error("insertion enabled after reset");

  global_override_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r.globalInsert && txSlotIndex == state_r.slotSel) |-> txSlotInsert.valid)
    else $error("global insertion enable ignored");

  rx_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rxSlot.valid && rxSlot.index == state_r.slotSel && !wrEn)
    |=> (state_r.rxByte == $past(rxSlot.data)))
    else $error("selected receive byte not captured");

  pin_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_r.pin_driven_reset_gen_enable |=> (txResetRequest == $past(external_reset_request_in)))
    else $error("pin mode request does not follow input");

  sw_masked_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r.pin_driven_reset_gen_enable && !external_reset_request_in) |=> !txResetRequest)
    else $error("software bits not masked in pin mode");

  sw_force_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!state_r.pin_driven_reset_gen_enable && state_r.resetGenEn)
    |=> (txResetRequest == $past(state_r.resetForce)))
    else $error("software mode ignores force bit");

  detect_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    linkResetDetected |=> state_r.detectHold)
    else $error("detect hold not set");

  done_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    linkResetSent |=> state_r.doneHold)
    else $error("sent hold not set");

  reset_out_a: assert property (@(posedge clk_sys) disable iff (rst)
    resetOut |-> $past(state_r.resetOutEn && linkResetDetected))
    else $error("reset output without enable");

  frame_track_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> (state_r.frame == $past(frameNumber)))
    else $error("frame number not tracked");

  slot_write_c: cover property (@(posedge clk_sys) disable iff (rst)
    wrEn && paddr == crc_pkg::ADDR_SLOT);
  hold_clear_c: cover property (@(posedge clk_sys) disable iff (rst)
    state_r.detectHold ##1 rdEn && paddr == crc_pkg::ADDR_RST ##1 !state_r.detectHold);
  pin_request_c: cover property (@(posedge clk_sys) disable iff (rst)
    state_r.pin_driven_reset_gen_enable && txResetRequest);
  insert_c: cover property (@(posedge clk_sys) disable iff (rst) txSlotInsert.valid);

endmodule // crc_ctrl_regs

`default_nettype wire

// ### crc_lcv_counter.sv
`timescale 1ns/10ps
`default_nettype none

module crc_lcv_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Violation pulse and count.
  input wire logic violation,
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } crc_lcv_state_t;

  crc_lcv_state_t state_r;
  crc_lcv_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // Sticks at all-ones until reset; it is a debug aid, not a link-loss judge.
    if (violation && (state_r.count != {WIDTH{1'b1}})) begin
      state_nxt.count = state_r.count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count = state_r.count;

  saturate_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (count == {WIDTH{1'b1}}) |=> (count == {WIDTH{1'b1}}))
    else $error("violation counter left saturation");

  count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (violation && count != {WIDTH{1'b1}}) |=> (count == $past(count) + 1'b1))
    else $error("violation counter did not step by one");

  count_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !violation |=> $stable(count))
    else $error("violation counter moved without a violation");

endmodule // crc_lcv_counter

`default_nettype wire

// ### crc_link_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========
// Far-end link model.
module crc_link_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Commands from the bench.
  input wire logic sendGo,
  input wire logic [15:0] sendWord,
  input wire logic violGo,
  input wire logic farReset,
  // Link side of the device.
  input wire logic txResetRequest,
  output crc_pkg::crc_slot_t rxSlot,
  output logic codeViolation,
  output logic linkResetDetected,
  output logic [7:0] txSlotIndex,
  output logic linkResetSent
);
  // The framer walks every control position in turn and never pauses.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txSlotIndex <= 8'h00;
      linkResetSent <= 1'b0;
    end else begin
      txSlotIndex <= txSlotIndex + 8'h01;
      linkResetSent <= txResetRequest;
    end
  end
  // Outside a strobe the data lines show the inverse, so a stale byte is never mistaken for news.
  assign rxSlot = {sendGo, sendWord[15:8], sendGo ? sendWord[7:0] : ~sendWord[7:0]};
  assign codeViolation = violGo;
  assign linkResetDetected = farReset;
endmodule // crc_link_model

`default_nettype wire

// ### crc_pkg.sv
package crc_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_SLOT = 8'h0C;
  localparam logic [7:0] ADDR_RXCTRL = 8'h10;
  localparam logic [7:0] ADDR_TXCTRL = 8'h14;
  localparam logic [7:0] ADDR_LCV = 8'h18;
  localparam logic [7:0] ADDR_FRAME = 8'h1C;
  localparam logic [7:0] ADDR_RST = 8'h20;

  // Field positions.
  localparam int CFG_INSERT_BIT = 0;
  localparam int TX_INSERT_BIT = 8;
  localparam int RST_GEN_EN_BIT = 0;
  localparam int RST_FORCE_BIT = 1;
  localparam int RST_OUT_EN_BIT = 2;
  localparam int RST_PIN_EN_BIT = 3;
  localparam int RST_DET_BIT = 4;
  localparam int RST_DET_HOLD_BIT = 5;
  localparam int RST_DONE_BIT = 6;
  localparam int RST_DONE_HOLD_BIT = 7;

  // Reset values and limits.
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] LCV_FULL = 8'hFF;
  localparam logic [3:0] RST_CTRL_RESET = 4'h0;

  // APB request carrier.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } crc_apb_req_t;

  // Link-side control-byte slot carrier.
  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [7:0] data;
  } crc_slot_t;

endpackage
